//--- hw/sbt_map.svh
`ifndef SBT_MAP_SVH
`define SBT_MAP_SVH
// ----------------------------------------
// Frame lengths in bit times
// ----------------------------------------
`define SBT_BITS_SHORT 4'd10
`define SBT_BITS_LONG 4'd11
// ----------------------------------------
// Baud divider reset value
// ----------------------------------------
`define SBT_DIV_RESET 16'h00c9
`define SBT_DIV_WIDTH 16
`endif

//--- hw/sbt_pkg.sv
package sbt_pkg;
  typedef enum logic [1:0] {
    SBT_IDLE = 2'b00,
    SBT_PREAMBLE = 2'b10,
    SBT_BREAK = 2'b01
  } sbt_state_type;
endpackage

//--- hw/sbt_baud_tick.sv
`timescale 1ns/100ps
`include "sbt_map.svh"
module sbt_baud_tick #(
  parameter int DIV_W = `SBT_DIV_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Control
  input wire logic restart_in,
  input wire logic [DIV_W-1:0] divider_in,
  // Bit tick
  output logic tick_out
);
  logic [DIV_W-1:0] count_reg;

  // ----------------------------------------
  // Bit time counter
  // ----------------------------------------
  // Restart preloads one, else the first bit runs a clock long
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      count_reg <= '0;
    end else if (restart_in) begin
      count_reg <= DIV_W'(1);
    end else if (count_reg >= divider_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= restart_in ? (divider_in == '0) : (count_reg >= divider_in);
    end
  end
endmodule // sbt_baud_tick

//--- hw/sbt_break_tx.sv
`timescale 1ns/100ps
`include "sbt_map.svh"
// Summary of operation
// - Setting then clearing break_request before the break ends sends exactly one break character.
// - Break lasts 10 bit times, or 11 with long word length; never doubled.
// - Breaks repeat back to back while break_request stays set.
// - Re-enabling the transmitter queues one idle line before next transmission.
// - Idle immediately followed by break gives break of exact nominal length.
module sbt_break_tx
  import sbt_pkg::*;
#(
  parameter int DIV_W = `SBT_DIV_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Control bits from serial_control_reg_two
  input wire logic break_request_in,
  input wire logic transmitter_enable_bit_in,
  input wire logic word_long_in,
  input wire logic [DIV_W-1:0] baud_rate_divider_in,
  // Serial line and status
  output logic serial_tx_out,
  output logic break_active_out,
  output logic idle_active_out
);
  sbt_state_type state_reg;
  sbt_state_type state_next;
  logic [3:0] bit_count_reg;
  logic [3:0] frame_len;
  logic word_long_reg;
  logic frame_end;
  logic enable_d_reg;
  logic idle_pending_reg;
  logic break_pending_reg;
  logic tick;
  logic restart;

  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  assign restart = (state_reg == SBT_IDLE);

  sbt_baud_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .restart_in(restart),
    .divider_in(baud_rate_divider_in),
    .tick_out(tick)
  );

  // ----------------------------------------
  // Frame length
  // ----------------------------------------
  // word size latched at frame start
  // A word length change mid-frame would otherwise bend the break
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      word_long_reg <= 1'b0;
    end else if (state_reg == SBT_IDLE) begin
      word_long_reg <= word_long_in;
    end
  end

  assign frame_len = word_long_reg ? `SBT_BITS_LONG : `SBT_BITS_SHORT;

  // Last bit time of the current frame
  assign frame_end = tick && (bit_count_reg == frame_len - 4'd1);

  // ----------------------------------------
  // Request capture
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      enable_d_reg <= 1'b0;
    end else begin
      enable_d_reg <= transmitter_enable_bit_in;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idle_pending_reg <= 1'b0;
    end else if (transmitter_enable_bit_in && !enable_d_reg) begin
      idle_pending_reg <= 1'b1;
    end else if (state_reg == SBT_PREAMBLE && frame_end) begin
      idle_pending_reg <= 1'b0;
    end
  end

  // a short pulse still yields one break
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      break_pending_reg <= 1'b0;
    end else if (break_request_in && transmitter_enable_bit_in) begin
      break_pending_reg <= 1'b1;
    end else if (state_reg == SBT_BREAK) begin
      break_pending_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SBT_IDLE: begin
        // idle first, then break from a fresh bit boundary
        if (!transmitter_enable_bit_in) begin
          state_next = SBT_IDLE;
        end else if (idle_pending_reg) begin
          state_next = SBT_PREAMBLE;
        end else if (break_pending_reg) begin
          state_next = SBT_BREAK;
        end
      end
      SBT_PREAMBLE: begin
        if (frame_end) begin
          state_next = SBT_IDLE;
        end
      end
      SBT_BREAK: begin
        if (frame_end) begin
          state_next = (break_request_in && transmitter_enable_bit_in) ? SBT_BREAK : SBT_IDLE;
        end
      end
      default: begin
        state_next = SBT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= SBT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // count restarts per frame, so no doubling
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      bit_count_reg <= 4'h0;
    end else if (state_reg == SBT_IDLE) begin
      bit_count_reg <= 4'h0;
    end else if (tick) begin
      bit_count_reg <= frame_end ? 4'h0 : bit_count_reg + 4'd1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // low through break, high otherwise
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_tx_out <= 1'b1;
    end else begin
      serial_tx_out <= (state_next != SBT_BREAK);
    end
  end

  // Break status, aligned with the line
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      break_active_out <= 1'b0;
    end else begin
      break_active_out <= (state_next == SBT_BREAK);
    end
  end

  // Idle preamble status
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      idle_active_out <= 1'b0;
    end else begin
      idle_active_out <= (state_next == SBT_PREAMBLE);
    end
  end
endmodule // sbt_break_tx

//--- testbench/sbt_break_tx_assertions.sv
`timescale 1ns/100ps
module sbt_chk #(parameter int DIV_W = 16) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic break_request_in,
  input wire logic transmitter_enable_bit_in,
  input wire logic word_long_in,
  input wire logic [DIV_W-1:0] baud_rate_divider_in,
  input wire logic serial_tx_out,
  input wire logic break_active_out,
  input wire logic idle_active_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  brk_low_a: assert property (break_active_out |-> !serial_tx_out)
    else $error("line high in break");
  low_cause_a: assert property (!serial_tx_out |-> break_active_out)
    else $error("line low outside break");
  idle_high_a: assert property (idle_active_out |-> serial_tx_out)
    else $error("line low in idle");
  no_start_a: assert property (!transmitter_enable_bit_in && !break_active_out
    |=> !break_active_out) else $error("break while disabled");
  brk_ans_a: assert property ($rose(break_request_in) && transmitter_enable_bit_in
    && !idle_active_out && !break_active_out |-> ##2 break_active_out) else $error("no break");
  brk_repeat_a: assert property (break_active_out && break_request_in
    && transmitter_enable_bit_in |=> break_active_out) else $error("no repeat");
endmodule // sbt_chk
bind sbt_break_tx sbt_chk #(.DIV_W(DIV_W)) u_chk (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
  .break_request_in(break_request_in), .transmitter_enable_bit_in(transmitter_enable_bit_in),
  .word_long_in(word_long_in), .baud_rate_divider_in(baud_rate_divider_in),
  .serial_tx_out(serial_tx_out), .break_active_out(break_active_out),
  .idle_active_out(idle_active_out));

//--- testbench/sbt_line_rx.sv
`timescale 1ns/100ps
module sbt_line_rx (
  input wire logic ref_clk_in,
  input wire logic line_in,
  output int low_len_out,
  output int lows_out
);
  int cnt = 0;
  initial lows_out = 0;
  // Length of each low stretch, in clocks
  always @(posedge ref_clk_in) begin
    if (line_in === 1'b0) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      low_len_out <= cnt;
      lows_out <= lows_out + 1;
      cnt <= 0;
    end
  end
endmodule // sbt_line_rx

//--- testbench/sbt_break_tx_tb.sv
`timescale 1ns/100ps
`include "sbt_map.svh"
module sbt_break_tx_tb;
  logic clk = 0, rst = 1, req = 0, en = 0, wl = 0, tx, ba, ia;
  int low_len, lows, fails = 0, n_checks = 0;
  always #2 clk = ~clk;
  // Bit time of two clocks keeps frames short
  sbt_break_tx u_dut (.ref_clk_in(clk), .reset_in(rst), .break_request_in(req),
    .transmitter_enable_bit_in(en), .word_long_in(wl), .baud_rate_divider_in(16'h0001),
    .serial_tx_out(tx), .break_active_out(ba), .idle_active_out(ia));
  sbt_line_rx u_rx (.ref_clk_in(clk), .line_in(tx), .low_len_out(low_len), .lows_out(lows));
  task chk(input bit ok, input int got, input int exp);
    n_checks++;
    if (!ok) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task wait_low(input int n0);
    for (int i = 0; i < 400 && lows == n0; i++) @(posedge clk);
    if (lows == n0) begin
      chk(1'b0, lows, n0 + 1);
      final_report;
    end
  endtask
  task t_single(input bit m);
    int n0, b;
    b = m ? `SBT_BITS_LONG : `SBT_BITS_SHORT;
    @(posedge clk) wl <= m;
    en <= 0;
    @(posedge clk) en <= 1;
    repeat (4) @(posedge clk);
    #1 chk(ia === 1'b1, ia, 1);
    n0 = lows;
    @(posedge clk) req <= 1;
    @(posedge clk) req <= 0;
    wait_low(n0);
    chk(low_len == 2 * b, low_len, 2 * b);
    repeat (40) @(posedge clk);
    chk(lows == n0 + 1 && tx === 1'b1, lows, n0 + 1);
  endtask
  task t_repeat;
    int n0;
    n0 = lows;
    @(posedge clk) wl <= 0;
    req <= 1;
    repeat (50) @(posedge clk);
    req <= 0;
    wait_low(n0);
    chk(low_len == 3 * 2 * `SBT_BITS_SHORT, low_len, 3 * 2 * `SBT_BITS_SHORT);
  endtask
  task t_refuse;
    int n0;
    n0 = lows;
    @(posedge clk) en <= 0;
    req <= 1;
    repeat (60) @(posedge clk);
    req <= 0;
    #1 chk(lows == n0 && tx === 1'b1, lows, n0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    chk(tx === 1'b1, tx, 1);
    rst <= 0;
    t_single(0);
    t_single(1);
    t_repeat;
    t_refuse;
    final_report;
  end
endmodule // sbt_break_tx_tb
